// ==== test/mdo_host_model.sv ====
`timescale 1ns/1ps
module mdo_host_model
  import mdo_pkg::*;
#(
  parameter int MIN_DEAD_CODE = 8
) (
  input wire logic i_clk,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // Never program a gap below 360 ns
    if (a == ADDR_RAMP_DEAD && v[3:0] < MIN_DEAD_CODE) begin
      v[3:0] = 4'(MIN_DEAD_CODE);
    end
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = v;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    // Released lines show garbage, not the last value
    o_addr = ~a;
    o_wdata = ~v;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule // mdo_host_model

// ==== test/tb_motor_drive_option_registers.sv ====
`timescale 1ns/1ps
module tb_motor_drive_option_registers;
  import mdo_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic wr_en, rd_en;
  logic [7:0] addr, wdata, rdata;
  logic [4:0] ho_code = 5'h00;
  logic [15:0] speed = 16'h0000;
  logic elec = 1'b0;
  logic cl = 1'b0;
  logic fol = 1'b0;
  logic [2:0] hs_req = 3'h0;
  logic [2:0] ls_req = 3'h0;
  logic accel_en, nozc_cl, ramp_imm, inductive_position_detect, nozc_ol, buck, pwm, ho_go, tach;
  logic [11:0] accel_ma, lock_ma, sense_ma;
  logic [15:0] ramp, ho_spd;
  logic [7:0] rate;
  logic [3:0] kt_hi, kt_lo;
  logic [2:0] hs, ls;
  int err_total = 0;
  int n_tests = 0;

  always #4 clk = ~clk;

  mdo_host_model host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata));

  mdo_option_regs uut (.i_clk(clk), .i_arst_n(arst_n), .i_ce(ce),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .i_handover_code(ho_code), .i_speed_chz(speed), .i_elec_cycle(elec),
    .i_closed_loop(cl), .i_first_open_loop(fol), .i_hs_req(hs_req),
    .i_ls_req(ls_req), .o_rdata(rdata), .o_accel_limit_en(accel_en),
    .o_accel_limit_ma(accel_ma), .o_lock_limit_ma(lock_ma),
    .o_nozc_closed_en(nozc_cl), .o_ramp_immediate(ramp_imm),
    .o_ramp_mvcc_s(ramp), .o_inductive_position_detect(inductive_position_detect),
    .o_sense_thr_ma(sense_ma), .o_nozc_open_en(nozc_ol),
    .o_buck_3v3_sel(buck), .o_position_sense_rate_hz(rate),
    .o_kt_high_q4(kt_hi), .o_kt_low_q4(kt_lo), .o_speed_pwm_mode(pwm),
    .o_handover_speed_chz(ho_spd), .o_handover_go(ho_go),
    .o_tach_output(tach), .o_high_side(hs), .o_low_side(ls));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Decoded outputs land one edge after the register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write(a, d);
    @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.read(a, d);
    check(16'(d), 16'(e));
  endtask

  task automatic t_reset;
    rd_chk(ADDR_CUR_LIMIT, RST_CUR_LIMIT);
    rd_chk(ADDR_RAMP_DEAD, RST_RAMP_DEAD);
    rd_chk(ADDR_SENSE, RST_SENSE);
    rd_chk(ADDR_TACH, RST_TACH);
    rd_chk(8'h2C, 8'h00);
    rd_chk(8'h27, 8'h00);
    check(16'(accel_en), 16'h0000);
    check(16'(lock_ma), 16'(1 * 400));
    check(16'(ramp_imm), 16'h0001);
    check(16'(inductive_position_detect), 16'h0000);
    check(16'(rate), 16'h000C);
  endtask

  task automatic t_cur;
    logic [7:0] v [3] = '{8'hFF, 8'h10, 8'h01};
    int n, m;
    foreach (v[i]) begin
      wr(ADDR_CUR_LIMIT, v[i]);
      n = v[i][7:4];
      m = v[i][3:1];
      check(16'(accel_en), 16'(n != 0));
      check(16'(accel_ma), 16'(n * 200));
      check(16'(lock_ma), 16'((m + 1) * 400));
      rd_chk(ADDR_CUR_LIMIT, v[i] & 8'hFE);
    end
  endtask

  task automatic t_ramp;
    logic [15:0] t [8] = '{16'h0000, 16'hBB80, 16'hBB80, 16'h0302,
      16'h0172, 16'h00BE, 16'h005B, 16'h002D};
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[0], i[2:0], 4'h9};
      wr(ADDR_RAMP_DEAD, d);
      check(16'(nozc_cl), 16'(i[0]));
      check(16'(ramp_imm), 16'(i == 0));
      check(ramp, t[i]);
      rd_chk(ADDR_RAMP_DEAD, d);
    end
  endtask

  task automatic t_sense;
    logic [7:0] r [4] = '{8'h0C, 8'h18, 8'h2F, 8'h5F};
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {4'(i * 5), i[0], i[1], 2'(i)};
      wr(ADDR_SENSE, d);
      check(16'(inductive_position_detect), 16'(i != 0));
      if (i != 0)
        check(16'(sense_ma), 16'((i * 5 + 1) * 200));
      check(16'(nozc_ol), 16'(i[0]));
      check(16'(buck), 16'(i[1]));
      check(16'(rate), 16'(r[i]));
      rd_chk(ADDR_SENSE, d);
    end
  endtask

  task automatic t_kt;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_TACH, {4'h0, 2'(i), i[0], 1'b0});
      check(16'(kt_hi), i[0] ? 16'h0008 : 16'h0006);
      check(16'(kt_lo), i[1] ? 16'h0002 : 16'h0003);
      check(16'(pwm), 16'(i[0]));
    end
  endtask

  task automatic t_hand(input logic [4:0] c, input logic [15:0] s,
    input logic inh, input logic [15:0] et, input logic eg);
    wr(ADDR_TACH, {7'h00, inh});
    ho_code = c;
    speed = s;
    repeat (2) @(posedge clk);
    #1;
    check(ho_spd, et);
    check(16'(ho_go), 16'(eg));
  endtask

  // Six pulses bring any divider phase back to where it began
  task automatic t_tach(input logic [3:0] cfg, input logic c,
    input logic f, input int e);
    int n;
    wr(ADDR_TACH, {cfg, 4'h0});
    cl = c;
    fol = f;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      #1;
      elec = 1'b1;
      @(posedge clk);
      #1;
      elec = 1'b0;
      if (tach === 1'b1) n++;
      @(posedge clk);
      #1;
      if (tach !== 1'b0) n += 10;
    end
    check(16'(n), 16'(e));
  endtask

  // Writes while the enable is low must not land
  task automatic t_ce;
    ce = 1'b0;
    host.write(ADDR_SENSE, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check(16'(inductive_position_detect), 16'h0001);
    check(16'(buck), 16'h0001);
    ce = 1'b1;
    host.write(8'h2C, 8'h00);
    rd_chk(ADDR_SENSE, 8'hFF);
    rd_chk(8'h2C, 8'h00);
  endtask

  task automatic count_gap(output int n);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (hs === 3'h0 && ls === 3'h0) n++;
    end
  endtask

  task automatic t_gate;
    int n;
    wr(ADDR_RAMP_DEAD, 8'h08);
    hs_req = 3'h7;
    @(posedge clk);
    #1;
    check(16'(hs), 16'h0007);
    hs_req = 3'h0;
    ls_req = 3'h7;
    count_gap(n);
    check(16'(n), 16'((8 + 1) * 40 / 8));
    check(16'(ls), 16'h0007);
    // Back the other way, then both asked at once
    ls_req = 3'h0;
    hs_req = 3'h7;
    count_gap(n);
    check(16'(n), 16'((8 + 1) * 40 / 8));
    check(16'(hs), 16'h0007);
    ls_req = 3'h7;
    @(posedge clk);
    #1;
    check(16'(hs | ls), 16'h0000);
    hs_req = 3'h0;
    ls_req = 3'h0;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    // Divider is at zero after reset and again after each six-pulse run
    t_tach(4'h2, 1'b0, 1'b0, 3);
    t_tach(4'h0, 1'b0, 1'b0, 6);
    t_tach(4'h1, 1'b0, 1'b0, 4);
    t_tach(4'h3, 1'b0, 1'b0, 2);
    t_tach(4'h4, 1'b0, 1'b0, 0);
    t_tach(4'h4, 1'b1, 1'b0, 6);
    t_tach(4'h8, 1'b0, 1'b1, 6);
    t_tach(4'h8, 1'b0, 1'b0, 0);
    t_tach(4'hC, 1'b0, 1'b0, 6);
    t_cur();
    t_ramp();
    t_sense();
    t_kt();
    t_hand(5'h05, 16'h0190, 1'b0, 16'h0190, 1'b1);
    t_hand(5'h05, 16'h018F, 1'b0, 16'h0190, 1'b0);
    t_hand(5'h11, 16'h0A00, 1'b0, 16'h0A00, 1'b1);
    t_hand(5'h11, 16'h0A00, 1'b1, 16'h0A00, 1'b0);
    t_hand(5'h1F, 16'h8000, 1'b0, 16'h5000, 1'b1);
    t_hand(5'h00, 16'hFFFF, 1'b0, 16'h0000, 1'b0);
    t_ce();
    t_gate();
    complete_run();
  end

  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule // tb_motor_drive_option_registers

// ==== verilog/mdo_gate_phase.sv ====
`timescale 1ns/1ps
module mdo_gate_phase
  import mdo_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_hs_req,
  input wire logic i_ls_req,
  input wire logic [6:0] i_dead_cycles,
  output logic o_high_side,
  output logic o_low_side
);
  mdo_gate_st_t st_q;
  logic [6:0] gap_q;
  logic want_hs;
  logic want_ls;

  // Both requested is treated as neither, never shoot-through
  assign want_hs = i_hs_req & ~i_ls_req;
  assign want_ls = i_ls_req & ~i_hs_req;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= GATE_IDLE;
      gap_q <= 7'h00;
      o_high_side <= 1'b0;
      o_low_side <= 1'b0;
    end else if (i_ce) begin
      case (st_q)
        GATE_IDLE: begin
          if (want_hs) begin
            st_q <= GATE_HIGH;
            o_high_side <= 1'b1;
          end else if (want_ls) begin
            st_q <= GATE_LOW;
            o_low_side <= 1'b1;
          end
        end
        GATE_HIGH, GATE_LOW: begin
          if ((st_q == GATE_HIGH) ? !want_hs : !want_ls) begin
            st_q <= GATE_GAP;
            gap_q <= i_dead_cycles - 7'h01;
            o_high_side <= 1'b0;
            o_low_side <= 1'b0;
          end
        end
        default: begin
          if (gap_q != 7'h00) begin
            gap_q <= gap_q - 7'h01;
          end else if (want_hs) begin
            st_q <= GATE_HIGH;
            o_high_side <= 1'b1;
          end else if (want_ls) begin
            st_q <= GATE_LOW;
            o_low_side <= 1'b1;
          end else begin
            st_q <= GATE_IDLE;
          end
        end
      endcase
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  no_overlap_a: assert property (!(o_high_side && o_low_side))
    else $error("Both gate sides on");
  hs_gap_a: assert property ($fell(o_high_side) |-> !o_low_side [*5])
    else $error("Low side on inside dead time");
  ls_gap_a: assert property ($fell(o_low_side) |-> !o_high_side [*5])
    else $error("High side on inside dead time");
endmodule // mdo_gate_phase

// ==== verilog/mdo_option_regs.sv ====
`timescale 1ns/1ps
// Behaviour
// - Accel current limit off at zero, else n times 0.2 A.
// - Lock current limit is (n + 1) times 0.4 A.
// - High bit enables closed-loop no-zero-cross fault detection.
// - Closed-loop ramp code maps to immediate, 48, 0.77 ... 0.045 Vcc/s.
// - Dead time between gate sides is (n + 1) times 40 ns per phase.
// - Sense threshold zero disables position sensing, else 0.2 A times n+1.
// - Bit 3 enables open-loop no-zero-cross fault detection.
// - Buck output is 5 V when clear, 3.3 V when set.
// - Position sense rate is 12, 24, 47 or 95 Hz.
// - Tach pulses in both loops, closed only, or closed plus first open.
// - Tach rate is 1/1, 2/3, 1/2 or 1/3 pulses per cycle.
// - Torque constant limits: high 3/2 or 2, low 3/4 or 1/2.
// - Speed input is analog when clear, PWM when set.
// - Clear allows closed-loop handover at threshold; set stays open loop.
// - Handover speed n times 0.8 Hz, or (n + 1) times 12.8 Hz.
module mdo_option_regs
  import mdo_pkg::*;
#(
  parameter int PHASES = 3
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [4:0] i_handover_code,
  input wire logic [15:0] i_speed_chz,
  input wire logic i_elec_cycle,
  input wire logic i_closed_loop,
  input wire logic i_first_open_loop,
  input wire logic [PHASES-1:0] i_hs_req,
  input wire logic [PHASES-1:0] i_ls_req,
  output logic [7:0] o_rdata,
  output logic o_accel_limit_en,
  output logic [11:0] o_accel_limit_ma,
  output logic [11:0] o_lock_limit_ma,
  output logic o_nozc_closed_en,
  output logic o_ramp_immediate,
  output logic [15:0] o_ramp_mvcc_s,
  output logic o_inductive_position_detect,
  output logic [11:0] o_sense_thr_ma,
  output logic o_nozc_open_en,
  output logic o_buck_3v3_sel,
  output logic [7:0] o_position_sense_rate_hz,
  output logic [3:0] o_kt_high_q4,
  output logic [3:0] o_kt_low_q4,
  output logic o_speed_pwm_mode,
  output logic [15:0] o_handover_speed_chz,
  output logic o_handover_go,
  output logic o_tach_output,
  output logic [PHASES-1:0] o_high_side,
  output logic [PHASES-1:0] o_low_side
);
  logic [7:1] cur_limit_q;
  logic [7:0] ramp_dead_q;
  logic [7:0] sense_q;
  logic [7:0] tach_q;
  logic [6:0] dead_cyc_q;
  logic [1:0] cyc_cnt_q;
  logic [3:0] accel_n;
  logic [2:0] lock_n;
  logic [3:0] ipd_n;
  logic [3:0] dead_n;
  logic [1:0] tach_sel;
  logic [1:0] tach_ratio;
  logic [1:0] cyc_wrap;
  logic tach_allow;
  logic tach_pick;
  logic [15:0] hand_thr;

  assign accel_n = cur_limit_q[ACCEL_LSB +: 4];
  assign lock_n = cur_limit_q[LOCK_LSB +: 3];
  assign ipd_n = sense_q[IPD_LSB +: 4];
  assign dead_n = ramp_dead_q[DEAD_LSB +: 4];
  assign tach_sel = tach_q[TSEL_LSB +: 2];
  assign tach_ratio = tach_q[TRATIO_LSB +: 2];

  // Register writes; bit 0 of the first register is not stored
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cur_limit_q <= RST_CUR_LIMIT[7:1];
      ramp_dead_q <= RST_RAMP_DEAD;
      sense_q <= RST_SENSE;
      tach_q <= RST_TACH;
    end else if (i_ce && i_wr_en) begin
      if (i_addr == ADDR_CUR_LIMIT) begin
        cur_limit_q <= i_wdata[7:1];
      end else if (i_addr == ADDR_RAMP_DEAD) begin
        ramp_dead_q <= i_wdata;
      end else if (i_addr == ADDR_SENSE) begin
        sense_q <= i_wdata;
      end else if (i_addr == ADDR_TACH) begin
        tach_q <= i_wdata;
      end
    end
  end

  // Read data held until the next read; unmapped reads return zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce && i_rd_en) begin
      if (i_addr == ADDR_CUR_LIMIT) begin
        o_rdata <= {cur_limit_q, 1'b0};
      end else if (i_addr == ADDR_RAMP_DEAD) begin
        o_rdata <= ramp_dead_q;
      end else if (i_addr == ADDR_SENSE) begin
        o_rdata <= sense_q;
      end else if (i_addr == ADDR_TACH) begin
        o_rdata <= tach_q;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // Current limits
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_accel_limit_en <= 1'b0;
      o_accel_limit_ma <= 12'h000;
      o_lock_limit_ma <= 12'h000;
      o_inductive_position_detect <= 1'b0;
      o_sense_thr_ma <= 12'h000;
    end else if (i_ce) begin
      o_accel_limit_en <= accel_n != 4'h0;
      o_accel_limit_ma <= 12'(accel_n) * ACCEL_STEP_MA;
      o_lock_limit_ma <= (12'(lock_n) + 12'h001) * LOCK_STEP_MA;
      o_inductive_position_detect <= ipd_n != 4'h0;
      // Threshold reported even when sensing is off; core ignores it
      o_sense_thr_ma <= (12'(ipd_n) + 12'h001) * IPD_STEP_MA;
    end
  end

  // Enables and selects
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_nozc_closed_en <= 1'b0;
      o_nozc_open_en <= 1'b0;
      o_buck_3v3_sel <= 1'b0;
      o_speed_pwm_mode <= 1'b0;
    end else if (i_ce) begin
      o_nozc_closed_en <= ramp_dead_q[NOZC_CL_BIT];
      o_nozc_open_en <= sense_q[NOZC_OL_BIT];
      o_buck_3v3_sel <= sense_q[BUCK_BIT];
      o_speed_pwm_mode <= tach_q[SPD_BIT];
    end
  end

  // Ramp rate, sense rate and torque constant tables
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ramp_immediate <= 1'b1;
      o_ramp_mvcc_s <= 16'h0000;
      o_position_sense_rate_hz <= SRATE_0;
      o_kt_high_q4 <= KT_HI_3_2;
      o_kt_low_q4 <= KT_LO_3_4;
    end else if (i_ce) begin
      o_ramp_immediate <= ramp_dead_q[RAMP_LSB +: 3] == 3'h0;
      case (ramp_dead_q[RAMP_LSB +: 3])
        3'h0: o_ramp_mvcc_s <= 16'h0000;
        3'h1, 3'h2: o_ramp_mvcc_s <= RAMP_FAST;
        3'h3: o_ramp_mvcc_s <= RAMP_R3;
        3'h4: o_ramp_mvcc_s <= RAMP_R4;
        3'h5: o_ramp_mvcc_s <= RAMP_R5;
        3'h6: o_ramp_mvcc_s <= RAMP_R6;
        default: o_ramp_mvcc_s <= RAMP_R7;
      endcase
      case (sense_q[SRATE_LSB +: 2])
        2'h0: o_position_sense_rate_hz <= SRATE_0;
        2'h1: o_position_sense_rate_hz <= SRATE_1;
        2'h2: o_position_sense_rate_hz <= SRATE_2;
        default: o_position_sense_rate_hz <= SRATE_3;
      endcase
      o_kt_high_q4 <= tach_q[KT_LSB] ? KT_HI_2 : KT_HI_3_2;
      o_kt_low_q4 <= tach_q[KT_LSB+1] ? KT_LO_1_2 : KT_LO_3_4;
    end
  end

  // Loop handover threshold and go decision
  assign hand_thr = i_handover_code[HAND_RANGE_BIT] ?
    (16'(i_handover_code[3:0]) + 16'h0001) * HAND_HI_STEP :
    16'(i_handover_code[3:0]) * HAND_LO_STEP;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_handover_speed_chz <= 16'h0000;
      o_handover_go <= 1'b0;
    end else if (i_ce) begin
      o_handover_speed_chz <= hand_thr;
      // Zero threshold means no handover point, so never go
      o_handover_go <= !tach_q[INHIBIT_BIT] && hand_thr != 16'h0000 &&
        i_speed_chz >= hand_thr;
    end
  end

  // Tach pulse divider; counts every cycle even while gated off
  assign cyc_wrap = (tach_ratio == 2'h2) ? 2'h1 : 2'h2;
  assign tach_allow = (tach_sel == 2'h1) ? i_closed_loop :
    (tach_sel == 2'h2) ? (i_closed_loop | i_first_open_loop) :
    1'b1;
  always_comb begin
    case (tach_ratio)
      2'h0: tach_pick = 1'b1;
      2'h1: tach_pick = cyc_cnt_q != 2'h2;
      default: tach_pick = cyc_cnt_q == 2'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cyc_cnt_q <= 2'h0;
      o_tach_output <= 1'b0;
    end else if (i_ce) begin
      o_tach_output <= i_elec_cycle && tach_allow && tach_pick;
      if (i_elec_cycle) begin
        cyc_cnt_q <= (cyc_cnt_q >= cyc_wrap) ? 2'h0 :
          cyc_cnt_q + 2'h1;
      end
    end
  end

  // Dead time in clock cycles, registered to keep the gate timing clean
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dead_cyc_q <= DEAD_STEP_CYC;
    end else if (i_ce) begin
      dead_cyc_q <= (7'(dead_n) + 7'h01) * DEAD_STEP_CYC;
    end
  end

  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    mdo_gate_phase u_gate (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_hs_req(i_hs_req[p]),
      .i_ls_req(i_ls_req[p]),
      .i_dead_cycles(dead_cyc_q),
      .o_high_side(o_high_side[p]),
      .o_low_side(o_low_side[p])
    );
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence wr_s(logic [7:0] a);
    i_ce && i_wr_en && i_addr == a ##1 i_ce;
  endsequence

  accel_limit_a: assert property (wr_s(ADDR_CUR_LIMIT) |=>
    o_accel_limit_en == ($past(i_wdata[7:4], 2) != 4'h0) &&
    o_accel_limit_ma == 12'($past(i_wdata[7:4], 2)) * ACCEL_STEP_MA)
    else $error("Accel limit mismatch");
  lock_limit_a: assert property (wr_s(ADDR_CUR_LIMIT) |=>
    o_lock_limit_ma ==
    (12'($past(i_wdata[3:1], 2)) + 12'h001) * LOCK_STEP_MA)
    else $error("Lock limit mismatch");
  nozc_closed_a: assert property (wr_s(ADDR_RAMP_DEAD) |=>
    o_nozc_closed_en == $past(i_wdata[7], 2))
    else $error("Closed loop fault enable mismatch");
  ramp_fast_a: assert property (wr_s(ADDR_RAMP_DEAD) ##0
    $past(i_wdata[6:5]) == 2'h0 && $past(i_wdata[4]) |=>
    o_ramp_mvcc_s == RAMP_FAST && !o_ramp_immediate)
    else $error("Ramp rate mismatch");
  dead_cycles_a: assert property (wr_s(ADDR_RAMP_DEAD) |=>
    dead_cyc_q == (7'($past(i_wdata[3:0], 2)) + 7'h01) * DEAD_STEP_CYC)
    else $error("Dead time mismatch");
  sense_thr_a: assert property (wr_s(ADDR_SENSE) |=>
    o_inductive_position_detect == ($past(i_wdata[7:4], 2) != 4'h0))
    else $error("Position sense enable mismatch");
  nozc_open_a: assert property (wr_s(ADDR_SENSE) |=>
    o_nozc_open_en == $past(i_wdata[3], 2))
    else $error("Open loop fault enable mismatch");
  buck_sel_a: assert property (wr_s(ADDR_SENSE) |=>
    o_buck_3v3_sel == $past(i_wdata[2], 2))
    else $error("Buck select mismatch");
  sense_rate_a: assert property (wr_s(ADDR_SENSE) ##0
    $past(i_wdata[1:0]) == 2'h3 |=> o_position_sense_rate_hz == SRATE_3)
    else $error("Sense rate mismatch");
  tach_gate_a: assert property ($past(i_ce) &&
    $past(tach_sel) == 2'h1 && !$past(i_closed_loop) |-> !o_tach_output)
    else $error("Tach pulse outside closed loop");
  tach_ratio_a: assert property (o_tach_output &&
    $past(tach_ratio) == 2'h2 |-> $past(cyc_cnt_q) == 2'h0 &&
    $past(i_elec_cycle))
    else $error("Tach divide mismatch");
  kt_limit_a: assert property (wr_s(ADDR_TACH) ##0
    $past(i_wdata[3:2]) == 2'h2 |=>
    o_kt_high_q4 == KT_HI_3_2 && o_kt_low_q4 == KT_LO_1_2)
    else $error("Torque constant limit mismatch");
  speed_mode_a: assert property (wr_s(ADDR_TACH) |=>
    o_speed_pwm_mode == $past(i_wdata[1], 2))
    else $error("Speed input mode mismatch");
  inhibit_a: assert property ($past(i_ce) &&
    $past(tach_q[INHIBIT_BIT]) |-> !o_handover_go)
    else $error("Handover while inhibited");
  hand_hi_a: assert property ($past(i_ce) &&
    $past(i_handover_code[4]) |-> o_handover_speed_chz ==
    (16'($past(i_handover_code[3:0])) + 16'h0001) * HAND_HI_STEP)
    else $error("Handover speed mismatch");
  bit0_zero_a: assert property (i_ce && i_rd_en &&
    i_addr == ADDR_CUR_LIMIT |=> o_rdata[0] == 1'b0)
    else $error("Unused bit reads one");
  ramp_imm_a: assert property (wr_s(ADDR_RAMP_DEAD) |=>
    o_ramp_immediate == ($past(i_wdata[6:4], 2) == 3'h0))
    else $error("Ramp immediate flag mismatch");
  ramp_slow_a: assert property (wr_s(ADDR_RAMP_DEAD) ##0
    $past(i_wdata[6:4]) == 3'h7 |=> o_ramp_mvcc_s == RAMP_R7)
    else $error("Slowest ramp rate mismatch");
  sense_val_a: assert property (wr_s(ADDR_SENSE) |=>
    o_sense_thr_ma ==
    (12'($past(i_wdata[7:4], 2)) + 12'h001) * IPD_STEP_MA)
    else $error("Sense threshold mismatch");
  sense_rate_lo_a: assert property (wr_s(ADDR_SENSE) ##0
    $past(i_wdata[1:0]) == 2'h0 |=> o_position_sense_rate_hz == SRATE_0)
    else $error("Slowest sense rate mismatch");
  rd_sense_a: assert property (i_ce && i_rd_en &&
    i_addr == ADDR_SENSE |=> o_rdata == $past(sense_q))
    else $error("Read data mismatch");
  kt_high_a: assert property (wr_s(ADDR_TACH) |=>
    o_kt_high_q4 == ($past(i_wdata[2], 2) ? KT_HI_2 : KT_HI_3_2))
    else $error("Torque constant upper limit mismatch");
  tach_all_a: assert property ($past(i_ce) && $past(i_elec_cycle) &&
    $past(tach_ratio) == 2'h0 &&
    $past(tach_sel[0]) == $past(tach_sel[1]) |-> o_tach_output)
    else $error("Tach pulse missing");
  handover_go_a: assert property ($past(i_ce) &&
    !$past(tach_q[INHIBIT_BIT]) && $past(hand_thr) != 16'h0000 &&
    $past(i_speed_chz) >= $past(hand_thr) |-> o_handover_go)
    else $error("Handover not taken");
  hand_lo_a: assert property ($past(i_ce) &&
    !$past(i_handover_code[4]) |-> o_handover_speed_chz ==
    16'($past(i_handover_code[3:0])) * HAND_LO_STEP)
    else $error("Low range handover speed mismatch");
  ce_hold_a: assert property (!i_ce |=> $stable(dead_cyc_q) &&
    $stable(o_high_side) && $stable(o_low_side) && $stable(o_rdata))
    else $error("State moved while enable low");
endmodule // mdo_option_regs

// ==== verilog/mdo_pkg.sv ====
package mdo_pkg;
  // Register offsets on the register port
  localparam logic [7:0] ADDR_CUR_LIMIT = 8'h28;
  localparam logic [7:0] ADDR_RAMP_DEAD = 8'h29;
  localparam logic [7:0] ADDR_SENSE = 8'h2A;
  localparam logic [7:0] ADDR_TACH = 8'h2B;
  // Values after reset
  localparam logic [7:0] RST_CUR_LIMIT = 8'h00;
  localparam logic [7:0] RST_RAMP_DEAD = 8'h00;
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic [7:0] RST_TACH = 8'h00;
  // Field positions
  localparam int ACCEL_LSB = 4;
  localparam int LOCK_LSB = 1;
  localparam int NOZC_CL_BIT = 7;
  localparam int RAMP_LSB = 4;
  localparam int DEAD_LSB = 0;
  localparam int IPD_LSB = 4;
  localparam int NOZC_OL_BIT = 3;
  localparam int BUCK_BIT = 2;
  localparam int SRATE_LSB = 0;
  localparam int TSEL_LSB = 6;
  localparam int TRATIO_LSB = 4;
  localparam int KT_LSB = 2;
  localparam int SPD_BIT = 1;
  localparam int INHIBIT_BIT = 0;
  localparam int HAND_RANGE_BIT = 4;
  // Scales: currents in mA, speeds in 0.01 Hz, ramps in mVcc/s
  localparam logic [11:0] ACCEL_STEP_MA = 12'h0C8;
  localparam logic [11:0] LOCK_STEP_MA = 12'h190;
  localparam logic [11:0] IPD_STEP_MA = 12'h0C8;
  localparam logic [15:0] HAND_LO_STEP = 16'h0050;
  localparam logic [15:0] HAND_HI_STEP = 16'h0500;
  localparam logic [15:0] RAMP_FAST = 16'hBB80;
  localparam logic [15:0] RAMP_R3 = 16'h0302;
  localparam logic [15:0] RAMP_R4 = 16'h0172;
  localparam logic [15:0] RAMP_R5 = 16'h00BE;
  localparam logic [15:0] RAMP_R6 = 16'h005B;
  localparam logic [15:0] RAMP_R7 = 16'h002D;
  localparam logic [7:0] SRATE_0 = 8'h0C;
  localparam logic [7:0] SRATE_1 = 8'h18;
  localparam logic [7:0] SRATE_2 = 8'h2F;
  localparam logic [7:0] SRATE_3 = 8'h5F;
  // Torque constant limits in quarters of nominal
  localparam logic [3:0] KT_HI_3_2 = 4'h6;
  localparam logic [3:0] KT_HI_2 = 4'h8;
  localparam logic [3:0] KT_LO_3_4 = 4'h3;
  localparam logic [3:0] KT_LO_1_2 = 4'h2;
  // Dead time
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEAD_STEP_NS = 40;
  localparam logic [6:0] DEAD_STEP_CYC =
    7'((DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    GATE_IDLE = 2'b00,
    GATE_HIGH = 2'b01,
    GATE_LOW = 2'b10,
    GATE_GAP = 2'b11
  } mdo_gate_st_t;
endpackage
